/* File: rtl/hwmon_limit_status_one.sv */
// hwmon_limit_status_one: first limit-status register of the hardware
// monitor, with its start, enable and event-interrupt registers.
// assumes readings and limits arrive on ref_clk_i, supply good is a pin.
//
// Operation
// [RQ1] rise of supply good returns status flags 6:0 to zero
// [RQ2] bit 7 follows the second status register's any-flag summary
// [RQ3] writes to the summary bit neither set nor clear it
// [RQ4] software reads the second status register only when bit 7 is set
// [RQ5] flags 6:0 latch on violation, hold until write-one or enable drop
// [RQ6] write-one clears a voltage flag only if its reading is now good
// [RQ7] write-one clears a temperature flag only if its event has ended
// [RQ8] writing zero to a flag leaves it unchanged
// [RQ9] no flag sets without start and its enable; enables act under start
// [RQ10] with start set, dropping a flag's enable clears it at once
// [RQ11] with start clear, dropping an enable leaves the flag alone
// [RQ12] raising start while a flag's enable is zero clears that flag
// [RQ13] toggling start with the enable set leaves the flag unchanged
// [RQ14] temperature group and global irq enables never touch flags
// [RQ15] voltage flags trip at or below low limit or above high limit
// [RQ16] temperature flags trip at or below low limit or above high limit
// [RQ17] temperature flag enables live in the register at index 82h
// [RQ18] start clear means no monitoring and no flags set
// [RQ19] a set and a clear of one flag together leave the flag set; a supply good rise still clears the flag against a set
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module hwmon_limit_status_one (
	input  wire logic                     ref_clk_i,
	input  wire logic                     rst_i,
	input  wire logic [7:0]               avs_address_i,
	input  wire logic                     avs_read_i,
	input  wire logic                     avs_write_i,
	input  wire logic [3:0]               avs_byteenable_i,
	input  wire logic [31:0]              avs_writedata_i,
	output logic [31:0]                   avs_readdata_o,
	output logic                          avs_waitrequest_o,
	input  hwmon_pkg::limit_chan_t [6:0]  chan_i,
	input  wire logic                     second_status_summary_i,
	input  wire logic                     supply_good_input_i,
	output logic                          irq_o
);
	import hwmon_pkg::*;

	function automatic logic reg_hit(input logic [7:0] a,
	                                 input logic [7:0] idx);
		reg_hit = (a == idx);
	endfunction

	// supply good synchroniser and rise detector
	logic pg_meta_reg;
	logic pg_sync_reg;
	logic pg_prev_reg;
	logic pg_rise;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			pg_meta_reg <= 1'b0;
			pg_sync_reg <= 1'b0;
			pg_prev_reg <= 1'b0;
		end else begin
			pg_meta_reg <= supply_good_input_i;
			pg_sync_reg <= pg_meta_reg;
			pg_prev_reg <= pg_sync_reg;
		end
	end

	assign pg_rise = pg_sync_reg & ~pg_prev_reg;

	// window comparators, one per flag
	logic [NUM_FLAGS-1:0] viol;

	for (genvar g = 0; g < NUM_FLAGS; g++) begin : g_chk
		limit_check #(
			.W (DATA_W)
		) u_chk (
			.ref_clk_i (ref_clk_i),
			.rst_i     (rst_i),
			.reading_i (chan_i[g].reading),
			.low_i     (chan_i[g].low_limit),
			.high_i    (chan_i[g].high_limit),
			.violate_o (viol[g])
		);
	end

	// bus slave: one wait state on every access, reads and writes alike
	logic ack_reg;
	logic bus_req;
	logic bus_done;
	logic wr_lane0;
	logic rd_done;

	assign bus_req           = avs_read_i | avs_write_i;
	assign avs_waitrequest_o = bus_req & ~ack_reg;
	assign bus_done          = bus_req & ack_reg;
	assign wr_lane0          = bus_done & avs_write_i & avs_byteenable_i[0];
	assign rd_done           = bus_done & avs_read_i;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= bus_req & ~ack_reg;
		end
	end

	logic [7:0] wdata;
	logic       wr_ctrl;
	logic       wr_stat;
	logic       wr_volt_en;
	logic       wr_temp_en;
	logic       wr_irq_mask;
	logic       rd_irq_stat;

	assign wdata       = avs_writedata_i[7:0];
	assign wr_ctrl     = wr_lane0 & reg_hit(avs_address_i, IDX_CTRL);
	assign wr_stat     = wr_lane0 & reg_hit(avs_address_i, IDX_STATUS1);
	assign wr_volt_en  = wr_lane0 & reg_hit(avs_address_i, IDX_VOLT_EN);
	assign wr_temp_en  = wr_lane0 & reg_hit(avs_address_i, IDX_TEMP_EN);
	assign wr_irq_mask = wr_lane0 & reg_hit(avs_address_i, IDX_IRQ_MASK);
	assign rd_irq_stat = rd_done & reg_hit(avs_address_i, IDX_IRQ_STAT);

	// control and enable registers
	logic [7:0] ctrl_reg;
	logic [7:0] volt_en_reg;
	logic [7:0] temp_en_reg;
	logic [7:0] irq_mask_reg;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			ctrl_reg <= RST_CTRL;
		end else if (wr_ctrl) begin
			ctrl_reg <= {5'h00, wdata[2:0]};
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			volt_en_reg <= RST_VOLT_EN;
		end else if (wr_volt_en) begin
			volt_en_reg <= {4'h0, wdata[3:0]};
		end
	end

	// temperature enables sit at their own index, low three bits
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			temp_en_reg <= RST_TEMP_EN;
		end else if (wr_temp_en) begin
			temp_en_reg <= {5'h00, wdata[2:0]}; // RQ17
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			irq_mask_reg <= RST_IRQ_MASK;
		end else if (wr_irq_mask) begin
			irq_mask_reg <= wdata;
		end
	end

	// flag engine
	logic                 start;
	logic [NUM_FLAGS-1:0] en_all;
	logic [NUM_FLAGS-1:0] set_cond;
	logic [NUM_FLAGS-1:0] clr_en;
	logic [NUM_FLAGS-1:0] clr_w1;
	logic [NUM_FLAGS-1:0] flags_reg;
	logic [NUM_FLAGS-1:0] flags_next;

	assign start  = ctrl_reg[CTRL_START_BIT];
	assign en_all = {temp_en_reg[NUM_TEMP-1:0], volt_en_reg[NUM_VOLT-1:0]};

	// enables are only looked at while start is high, so an enable that
	// drops under start clear waits for start to rise before it acts
	assign set_cond = {NUM_FLAGS{start}} & en_all & viol; // RQ9 RQ18
	assign clr_en   = {NUM_FLAGS{start}} & ~en_all; // RQ10 RQ11 RQ12 RQ13

	// a one clears only a flag whose condition has gone; bit 7 is dropped
	assign clr_w1 = wr_stat ? (wdata[6:0] & ~viol) : '0; // RQ3 RQ6 RQ7 RQ8

	always_comb begin
		if (pg_rise) begin
			flags_next = RST_FLAGS; // RQ1
		end else begin
			// set is or-ed last so it beats an enable-drop or write-one clear in the same cycle
			flags_next = (flags_reg & ~clr_en & ~clr_w1) | set_cond; // RQ5 RQ19
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			flags_reg <= RST_FLAGS;
		end else begin
			flags_reg <= flags_next;
		end
	end

	logic [7:0] status_val;

	// summary is live, never stored, so it drops as soon as the far side
	assign status_val = {second_status_summary_i, flags_reg}; // RQ2

	// event interrupts: new flag sets and summary rises are sticky
	logic       summary_prev_reg;
	logic [7:0] irq_ev;
	logic [7:0] irq_stat_reg;
	logic [7:0] grp_mask;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			summary_prev_reg <= 1'b0;
		end else begin
			summary_prev_reg <= second_status_summary_i;
		end
	end

	assign irq_ev = {second_status_summary_i & ~summary_prev_reg,
	                 set_cond & ~flags_reg};

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			irq_stat_reg <= RST_IRQ_STAT;
		end else if (rd_irq_stat) begin
			// clear only what the read returned, so an event that lands
			// in the wait cycle stays pending for the next read
			irq_stat_reg <= (irq_stat_reg & ~readdata_reg[7:0]) | irq_ev;
		end else begin
			irq_stat_reg <= irq_stat_reg | irq_ev;
		end
	end

	// group and global enables gate only the line, never the flags
	assign grp_mask = {1'b1, {NUM_TEMP{ctrl_reg[CTRL_TEMP_GRP]}},
	                   {NUM_VOLT{1'b1}}}; // RQ14
	assign irq_o    = ctrl_reg[CTRL_GLOBAL_IRQ] &
	                  (|(irq_stat_reg & irq_mask_reg & grp_mask)); // RQ14

	// read data is captured in the wait cycle and stands at completion
	logic [7:0]  rd_mux;
	logic [31:0] readdata_reg;

	always_comb begin
		if (reg_hit(avs_address_i, IDX_CTRL)) begin
			rd_mux = ctrl_reg;
		end else if (reg_hit(avs_address_i, IDX_STATUS1)) begin
			rd_mux = status_val;
		end else if (reg_hit(avs_address_i, IDX_VOLT_EN)) begin
			rd_mux = volt_en_reg;
		end else if (reg_hit(avs_address_i, IDX_TEMP_EN)) begin
			rd_mux = temp_en_reg;
		end else if (reg_hit(avs_address_i, IDX_IRQ_STAT)) begin
			rd_mux = irq_stat_reg;
		end else if (reg_hit(avs_address_i, IDX_IRQ_MASK)) begin
			rd_mux = irq_mask_reg;
		end else begin
			rd_mux = 8'h00;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			readdata_reg <= RST_RDATA;
		end else if (avs_read_i & ~ack_reg) begin
			readdata_reg <= {24'h00_0000, rd_mux};
		end
	end

	assign avs_readdata_o = readdata_reg;

	// checks
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	property p_pg_clear;
		pg_rise |=> (flags_reg == RST_FLAGS);
	endproperty
	a_pg_clear: assert property (p_pg_clear) // RQ1
		else $error("flags not cleared after supply good rise");

	property p_summary_read;
		rd_done && reg_hit(avs_address_i, IDX_STATUS1)
			|-> avs_readdata_o[SUMMARY_BIT] == $past(second_status_summary_i);
	endproperty
	a_summary_read: assert property (p_summary_read) // RQ2
		else $error("summary bit does not follow second status");

	property p_summary_wr;
		wr_stat && (wdata[6:0] == 7'h00) && !pg_rise
			|=> ((flags_reg & $past(flags_reg & ~clr_en)) ==
			     $past(flags_reg & ~clr_en));
	endproperty
	a_summary_wr: assert property (p_summary_wr) // RQ3
		else $error("write to summary bit disturbed flags");

	property p_set_latch;
		(set_cond != 7'h00) && !pg_rise
			|=> ((flags_reg & $past(set_cond)) == $past(set_cond));
	endproperty
	a_set_latch: assert property (p_set_latch) // RQ5
		else $error("violation did not set its flag");

	property p_volt_hold;
		wr_stat && !pg_rise
			|=> ((flags_reg[3:0] & $past(flags_reg[3:0] & viol[3:0]))
			     == $past(flags_reg[3:0] & viol[3:0]));
	endproperty
	a_volt_hold: assert property (p_volt_hold) // RQ6
		else $error("voltage flag cleared while still violating");

	property p_temp_hold;
		wr_stat && !pg_rise
			|=> ((flags_reg[6:4] & $past(flags_reg[6:4] & viol[6:4]))
			     == $past(flags_reg[6:4] & viol[6:4]));
	endproperty
	a_temp_hold: assert property (p_temp_hold) // RQ7
		else $error("temperature flag cleared while event active");

	property p_no_set_idle;
		!start |=> ((flags_reg & ~$past(flags_reg)) == 7'h00);
	endproperty
	a_no_set_idle: assert property (p_no_set_idle) // RQ9
		else $error("flag set while start clear");

	property p_en_drop;
		start && !pg_rise |=> ((flags_reg & ~$past(en_all)) == 7'h00);
	endproperty
	a_en_drop: assert property (p_en_drop) // RQ10
		else $error("flag with dropped enable not cleared under start");

	property p_idle_hold;
		!start && !wr_stat && !pg_rise |=> (flags_reg == $past(flags_reg));
	endproperty
	a_idle_hold: assert property (p_idle_hold) // RQ11
		else $error("flag changed while start clear");

	property p_irq_line;
		irq_o |-> ctrl_reg[CTRL_GLOBAL_IRQ] && (irq_stat_reg != 8'h00);
	endproperty
	a_irq_line: assert property (p_irq_line) // RQ14
		else $error("interrupt raised without pending event");

	c_flag_set:  cover property (start ##1 (flags_reg != 7'h00));
	c_w1_clear:  cover property (wr_stat ##1 (flags_reg == 7'h00));
	c_pg_clear:  cover property ((flags_reg != 7'h00) ##0 pg_rise);
	c_irq_raise: cover property (!irq_o ##1 irq_o);

endmodule

/* File: rtl/hwmon_pkg.sv */
// hwmon_pkg: register indices, field positions and reset values of the
// first limit-status block, and the limit channel carrier.
// assumes the bus carries word addresses, one register per 32-bit word.
package hwmon_pkg;

	localparam int unsigned REG_AW    = 8;
	localparam int unsigned DATA_W    = 8;
	localparam int unsigned NUM_FLAGS = 7;
	localparam int unsigned NUM_VOLT  = 4;
	localparam int unsigned NUM_TEMP  = 3;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_CTRL     = 8'h40;
	localparam logic [7:0] IDX_STATUS1  = 8'h41;
	localparam logic [7:0] IDX_VOLT_EN  = 8'h80;
	localparam logic [7:0] IDX_TEMP_EN  = 8'h82;
	localparam logic [7:0] IDX_IRQ_STAT = 8'h90;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h91;

	// control register fields
	localparam int unsigned CTRL_START_BIT  = 0;
	localparam int unsigned CTRL_TEMP_GRP   = 1;
	localparam int unsigned CTRL_GLOBAL_IRQ = 2;

	// status register layout
	localparam int unsigned SUMMARY_BIT = 7;
	localparam int unsigned VOLT_LSB    = 0;
	localparam int unsigned TEMP_LSB    = 4;

	// reset values
	localparam logic [7:0] RST_CTRL     = 8'h00;
	localparam logic [6:0] RST_FLAGS    = 7'h00;
	localparam logic [7:0] RST_VOLT_EN  = 8'h00;
	localparam logic [7:0] RST_TEMP_EN  = 8'h00;
	localparam logic [7:0] RST_IRQ_STAT = 8'h00;
	localparam logic [7:0] RST_IRQ_MASK = 8'h00;
	localparam logic [31:0] RST_RDATA   = 32'h0000_0000;

	// one converted quantity and its programmed window
	typedef struct packed {
		logic [7:0] reading;
		logic [7:0] low_limit;
		logic [7:0] high_limit;
	} limit_chan_t;

endpackage

/* File: rtl/limit_check.sv */
// limit_check: registered window comparator for one monitored quantity.
// assumes reading and limits come from logic on the same clock.
`timescale 1ns/10ps
module limit_check #(
	parameter int unsigned W = 8
) (
	input  wire logic         ref_clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] reading_i,
	input  wire logic [W-1:0] low_i,
	input  wire logic [W-1:0] high_i,
	output logic              violate_o
);

	// trips at or below the low limit, strictly above the high limit
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			violate_o <= 1'b0;
		end else begin
			violate_o <= (reading_i <= low_i) || (reading_i > high_i); // RQ15 RQ16
		end
	end

	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	property p_low_trip;
		(reading_i <= low_i) |=> violate_o;
	endproperty
	a_low_trip: assert property (p_low_trip) // RQ15
		else $error("reading at or below low limit did not trip");

	property p_window_ok;
		(reading_i > low_i) && (reading_i <= high_i) |=> !violate_o;
	endproperty
	a_window_ok: assert property (p_window_ok) // RQ16
		else $error("reading inside window tripped");

endmodule

/* File: sim/test_hwmon_limit_status_one.sv */
// test_hwmon_limit_status_one: self-checking bench for the first limit
// status register, its start and enable controls and the event irq.
// assumes a 250 MHz reference clock; bus wait states are not counted.
`timescale 1ns/10ps
module test_hwmon_limit_status_one;
	import hwmon_pkg::*;
	logic              ref_clk;
	logic              rst;
	logic [7:0]        address;
	logic              read;
	logic              write;
	logic [3:0]        byteenable;
	logic [31:0]       writedata;
	logic [31:0]       readdata;
	logic              waitrequest;
	limit_chan_t [6:0] chan;
	logic              summary;
	logic              supply_good;
	logic              irq;
	logic [31:0]       exp_q[$];
	int                errors = 0;
	int                samples_checked = 0;
	int                cycles = 0;

	hwmon_limit_status_one u_dut (
		.ref_clk_i               (ref_clk),
		.rst_i                   (rst),
		.avs_address_i           (address),
		.avs_read_i              (read),
		.avs_write_i             (write),
		.avs_byteenable_i        (byteenable),
		.avs_writedata_i         (writedata),
		.avs_readdata_o          (readdata),
		.avs_waitrequest_o       (waitrequest),
		.chan_i                  (chan),
		.second_status_summary_i (summary),
		.supply_good_input_i     (supply_good),
		.irq_o                   (irq)
	);

	initial ref_clk = 1'b0;
	always #2 ref_clk = ~ref_clk;

	task automatic conclude();
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// generous ceiling: the sequence needs well under a thousand cycles
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			errors++;
			$display("[FAIL] %0t run did not finish", $time);
			conclude();
		end
	end

	task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t read %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_irq(input logic exp);
		@(negedge ref_clk);
		samples_checked++;
		if (irq !== exp) begin
			errors++;
			$display("[FAIL] %0t irq %b expected %b", $time, irq, exp);
		end
	endtask

	// read data are taken at the edge that samples waitrequest low
	always @(posedge ref_clk) begin
		if (read === 1'b1 && waitrequest === 1'b0) begin
			if (exp_q.size() == 0) begin
				errors++;
				$display("[FAIL] %0t read with nothing expected", $time);
			end else begin
				cmp_data(readdata, exp_q.pop_front());
			end
		end
	end

	// the request stands until the edge that samples waitrequest low;
	// a slave that never answers is caught by the cycle ceiling
	task automatic acc(input logic wr, input logic [7:0] a,
			input logic [7:0] d);
		@(posedge ref_clk);
		address <= a;
		read <= ~wr;
		write <= wr;
		writedata <= {24'($urandom), d};
		do begin
			@(posedge ref_clk);
		end while (waitrequest !== 1'b0);
		read <= 1'b0;
		write <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		acc(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back({24'h000000, e});
		acc(1'b0, a, 8'h00);
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	// even channels sit on the low limit, odd ones just above the high one
	task automatic all_bad();
		for (int i = 0; i < 7; i++) begin
			chan[i].reading <= (i % 2 == 0) ? 8'h10 : 8'hF1;
		end
	endtask

	task automatic all_good();
		for (int i = 0; i < 7; i++) begin
			chan[i].reading <= 8'h11 + 8'($urandom_range(0, 8'hDF));
		end
	endtask

	initial begin
		void'($urandom(32'h1fd5));
		rst = 1'b1;
		address = 8'h00;
		read = 1'b0;
		write = 1'b0;
		byteenable = 4'hF;
		writedata = 32'h0000_0000;
		summary = 1'b0;
		supply_good = 1'b1;
		for (int i = 0; i < 7; i++) begin
			chan[i] = '{reading: 8'h80, low_limit: 8'h10, high_limit: 8'hF0};
		end
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		rd(IDX_STATUS1, 8'h00);
		rd(IDX_CTRL, 8'h00);
		rd(8'h3F, 8'h00);
		wr(IDX_VOLT_EN, 8'h0F);
		wr(IDX_TEMP_EN, 8'h07);
		all_bad();
		idle(4);
		rd(IDX_STATUS1, 8'h00);
		wr(IDX_CTRL, 8'h07);
		wr(IDX_IRQ_MASK, 8'hFF);
		idle(4);
		rd(IDX_STATUS1, 8'h7F);
		cmp_irq(1'b1);
		all_good();
		idle(4);
		rd(IDX_STATUS1, 8'h7F);
		wr(IDX_STATUS1, 8'h00);
		rd(IDX_STATUS1, 8'h7F);
		chan[0].reading <= 8'h10;
		chan[4].reading <= 8'hF1;
		idle(4);
		wr(IDX_STATUS1, 8'h7F);
		rd(IDX_STATUS1, 8'h11);
		all_good();
		idle(4);
		wr(IDX_STATUS1, 8'hFF);
		rd(IDX_STATUS1, 8'h00);
		summary <= 1'b1;
		rd(IDX_STATUS1, 8'h80);
		wr(IDX_STATUS1, 8'h80);
		rd(IDX_STATUS1, 8'h80);
		summary <= 1'b0;
		rd(IDX_STATUS1, 8'h00);
		all_bad();
		idle(4);
		wr(IDX_VOLT_EN, 8'h0E);
		rd(IDX_STATUS1, 8'h7E);
		all_good();
		idle(4);
		wr(IDX_CTRL, 8'h06);
		wr(IDX_TEMP_EN, 8'h06);
		rd(IDX_STATUS1, 8'h7E);
		wr(IDX_CTRL, 8'h07);
		rd(IDX_STATUS1, 8'h6E);
		wr(IDX_CTRL, 8'h01);
		rd(IDX_STATUS1, 8'h6E);
		cmp_irq(1'b0);
		wr(IDX_CTRL, 8'h07);
		cmp_irq(1'b1);
		rd(IDX_IRQ_STAT, 8'hFF);
		cmp_irq(1'b0);
		wr(IDX_IRQ_MASK, 8'h00);
		chan[0].reading <= 8'h10;
		wr(IDX_VOLT_EN, 8'h0F);
		idle(4);
		cmp_irq(1'b0);
		wr(IDX_IRQ_MASK, 8'h01);
		cmp_irq(1'b1);
		rd(IDX_IRQ_STAT, 8'h01);
		cmp_irq(1'b0);
		rd(IDX_STATUS1, 8'h6F);
		byteenable <= 4'h0;
		wr(IDX_CTRL, 8'h00);
		byteenable <= 4'hF;
		rd(IDX_CTRL, 8'h07);
		all_good();
		supply_good <= 1'b0;
		idle(4);
		supply_good <= 1'b1;
		idle(8);
		rd(IDX_STATUS1, 8'h00);
		idle(2);
		conclude();
	end
endmodule
